// File: verilog/cef_error_fault_sleep.sv
// Error detection, fault confinement, overload and low-power control of a CAN controller.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "cef_cfg.svh"

// How it works
// [R01] Compute the 15-bit CRC from start of frame to data end; mismatch flags crc error.
// [R02] Six equal levels in the stuffed region flag a stuffing error and start an error frame.
// [R03] A transmitted level read back differently flags a bit error and starts an error frame.
// [R04] Dominant level in CRC delimiter, ACK delimiter or end of frame is a form error.
// [R05] Transmitter finding the acknowledge slot recessive flags an acknowledge error.
// [R06] Separate transmit and receive error counters, readable in the error counter register.
// [R07] Start error active, go passive on accumulated errors, bus-off on extreme accumulation.
// [R08] Passive sends passive error flags and waits after sending; bus-off never drives.
// [R09] Either counter above 96 sets the warning bit while staying error active.
// [R10] Warning, bus-off, active and passive bits follow the counters, never latched.
// [R11] Active reads 1,0,0; passive reads 0,1,0; bus-off reads 0,1,1.
// [R12] Bus-off ends only after 128 runs of 11 recessive bits, or reset.
// [R13] Each status interrupt stays pending while its bit and mask bit are set.
// [R14] Dominant bit in early intermission, last end bit or last delimiter bit starts overload.
// [R15] With overload request enabled, send an overload frame after each mailbox message.
// [R16] Reactive overload works always and never raises an error counter.
// [R17] Asleep: no transmit, no receive, mailboxes inactive, counters stopped.
// [R18] Sleep and awake exclusive, both low after reset; awake needs 11 recessive bits.
// [R19] Low-power request enters sleep once pending transmissions end, then sets sleep.
// [R20] Awake setting clears sleep, sleep setting clears awake.
// [R21] Software waits for sleep before stopping the controller clock.
// [R22] Clearing the request resynchronises on 11 recessive bits, then sets awake.
// [R23] After wake, transmit only after the recessive run; a busy bus frame is discarded.
// [R24] Standard CAN polynomial and counter steps: +1 receive, +8 transmit, -1 success.
module cef_error_fault_sleep #(
	parameter int RECESSIVE_RUN = `CEF_RECESSIVE_RUN,
	parameter int BUSOFF_SEQS   = `CEF_BUSOFF_SEQS,
	parameter int SUSPEND_BITS  = `CEF_SUSPEND_BITS
) (
	// Clock and reset.
	input  wire logic                    sys_clk_in,
	input  wire logic                    rst_n_in,
	// Register port.
	input  wire logic [`CEF_ADDR_W-1:0]  reg_addr_in,
	input  wire logic [31:0]             reg_wdata_in,
	input  wire logic                    reg_wr_in,
	input  wire logic                    reg_rd_in,
	output logic      [31:0]             reg_rdata_out,
	// Bus pin and protocol engine.
	input  wire logic                    can_rx_in,
	input  wire cef_pkg::cef_bit_info_t  bit_info_in,
	input  wire cef_pkg::cef_frame_evt_t frame_evt_in,
	// Controls to the protocol engine.
	output logic                         error_frame_start_out,
	output logic                         error_flag_passive_out,
	output logic                         overload_frame_start_out,
	output logic                         bus_drive_enable_out,
	output logic                         tx_permit_out,
	output logic                         rx_enable_out,
	output logic                         irq_pending_out
);
	import cef_pkg::*;

	initial begin
		if (RECESSIVE_RUN < 1 || RECESSIVE_RUN > 15)
			$error("RECESSIVE_RUN must lie in 1..15");
		if (BUSOFF_SEQS < 1 || BUSOFF_SEQS > 255)
			$error("BUSOFF_SEQS must lie in 1..255");
		if (SUSPEND_BITS < 0 || SUSPEND_BITS > 15)
			$error("SUSPEND_BITS must lie in 0..15");
	end

	cef_state_t s;
	cef_state_t next_s;

	logic              rx;
	logic              tick;
	logic              busoff;
	logic              passive;
	logic              active;
	logic              warn;
	logic              sleeping;
	logic              awake;
	logic [`CEF_SR_W-1:0] status;
	logic              in_stuffed;
	logic              crc_feed;
	logic              crc_bit;
	logic              e_crc;
	logic              e_stuff;
	logic              e_bit;
	logic              e_form;
	logic              e_ack;
	logic              any_err;
	logic              reactive_ovl;
	logic              run_done;

	// Two stages keep the asynchronous bus level away from all decisions.
	assign rx       = s.rx_sync[1];
	assign tick     = bit_info_in.tick;
	assign sleeping = (s.lp == CEF_LP_SLEEP) || (s.lp == CEF_LP_WAKE);
	assign awake    = (s.lp == CEF_LP_AWAKE) || (s.lp == CEF_LP_DRAIN);

	assign busoff  = (s.transmit_error_counter > 9'(`CEF_BUSOFF_LIMIT)); // [R07]
	assign passive = busoff || (s.transmit_error_counter > 9'(`CEF_PASSIVE_LIMIT))
		|| (s.receive_error_counter > 8'(`CEF_PASSIVE_LIMIT)); // [R07]
	assign active  = !passive; // [R11]
	assign warn    = active && ((s.transmit_error_counter > 9'(`CEF_WARN_LIMIT))
		|| (s.receive_error_counter > 8'(`CEF_WARN_LIMIT))); // [R09]

	// Counter-derived bits are combinational so they never lag the counters.
	always_comb begin
		status = '0;
		status[`CEF_SR_ACTIVE]  = active; // [R10]
		status[`CEF_SR_PASSIVE] = passive; // [R11]
		status[`CEF_SR_BUSOFF]  = busoff; // [R11]
		status[`CEF_SR_WARN]    = warn; // [R10]
		status[`CEF_SR_SLEEP]   = sleeping; // [R18]
		status[`CEF_SR_AWAKE]   = awake; // [R18]
		status[`CEF_SR_ERR_LSB +: 5] = s.errs;
	end

	assign in_stuffed = (bit_info_in.field == CEF_FLD_ARB) || (bit_info_in.field == CEF_FLD_DATA)
		|| (bit_info_in.field == CEF_FLD_CRC);
	assign crc_feed = tick && !bit_info_in.stuff
		&& ((bit_info_in.field == CEF_FLD_ARB) || (bit_info_in.field == CEF_FLD_DATA));
	assign crc_bit  = rx ^ s.crc[14];
	assign run_done = (s.rrun == 4'(RECESSIVE_RUN - 1)) && tick && rx;

	// Detection is live only while the node may take part on the bus.
	always_comb begin
		e_crc   = 1'b0;
		e_stuff = 1'b0;
		e_bit   = 1'b0;
		e_form  = 1'b0;
		e_ack   = 1'b0;
		if (tick && awake && !busoff) begin
			if (bit_info_in.field == CEF_FLD_CRC_DELIM && s.crc_bad)
				e_crc = 1'b1; // [R01]
			if (in_stuffed && rx == s.last_bit
				&& s.srun == 3'(`CEF_STUFF_RUN - 1))
				e_stuff = 1'b1; // [R02]
			if (bit_info_in.transmitter && rx != bit_info_in.tx_level
				&& bit_info_in.field != CEF_FLD_ACK_SLOT
				&& !(bit_info_in.field == CEF_FLD_ARB && bit_info_in.tx_level))
				e_bit = 1'b1; // [R03]
			if (!rx && (bit_info_in.field == CEF_FLD_CRC_DELIM
				|| bit_info_in.field == CEF_FLD_ACK_DELIM
				|| (bit_info_in.field == CEF_FLD_EOF
				&& !(bit_info_in.last && !bit_info_in.transmitter))))
				e_form = 1'b1; // [R04]
			if (bit_info_in.transmitter && bit_info_in.field == CEF_FLD_ACK_SLOT && rx)
				e_ack = 1'b1; // [R05]
		end
	end

	assign any_err = e_crc | e_stuff | e_bit | e_form | e_ack;

	always_comb begin
		reactive_ovl = 1'b0;
		if (tick && awake && !busoff && !rx) begin
			if (bit_info_in.field == CEF_FLD_INTERMISSION && bit_info_in.index < 3'h2)
				reactive_ovl = 1'b1; // [R14]
			if (bit_info_in.field == CEF_FLD_EOF && bit_info_in.last
				&& !bit_info_in.transmitter)
				reactive_ovl = 1'b1; // [R14]
			if (bit_info_in.field == CEF_FLD_DELIM && bit_info_in.last)
				reactive_ovl = 1'b1; // [R14]
		end
	end

	always_comb begin
		next_s = s;
		next_s.rx_sync   = {s.rx_sync[0], can_rx_in};
		next_s.err_start = any_err; // [R02] [R03] [R05]
		next_s.ovl_start = reactive_ovl
			|| (s.ovl_en && frame_evt_in.rx_to_mailbox && awake); // [R15]
		next_s.rdata     = '0;

		// A raised error flag wins over a status read in the same cycle.
		if (reg_rd_in && reg_addr_in == `CEF_OFF_STATUS)
			next_s.errs = '0;
		next_s.errs = next_s.errs | {e_ack, e_form, e_bit, e_stuff, e_crc};

		// CRC over destuffed bits, then bitwise comparison against the read-back field.
		if (tick) begin
			if (bit_info_in.field == CEF_FLD_IDLE) begin
				next_s.crc     = '0;
				next_s.crc_bad = 1'b0;
			end else if (crc_feed) begin
				next_s.crc = {s.crc[13:0], 1'b0} ^ (crc_bit ? `CEF_CRC_POLY : 15'h0000); // [R24]
			end else if (bit_info_in.field == CEF_FLD_CRC && !bit_info_in.stuff) begin
				if (rx != s.crc[14])
					next_s.crc_bad = 1'b1; // [R01]
				next_s.crc = {s.crc[13:0], 1'b0};
			end
		end

		// Run length of equal levels inside the stuffed region.
		if (tick) begin
			next_s.last_bit = rx;
			if (!in_stuffed || rx != s.last_bit)
				next_s.srun = 3'h1;
			else if (s.srun != 3'h7)
				next_s.srun = s.srun + 3'h1; // [R02]
		end

		// Shared recessive-run counter for synchronisation and bus-off recovery.
		if (tick) begin
			if (!rx || run_done)
				next_s.rrun = '0;
			else
				next_s.rrun = s.rrun + 4'h1;
		end

		// Fault confinement counters, frozen while asleep.
		if (!sleeping && awake) begin // [R17]
			if (busoff) begin
				if (run_done) begin
					if (s.bo_seqs == 8'(BUSOFF_SEQS - 1)) begin
						next_s.bo_seqs = '0;
						next_s.transmit_error_counter     = '0; // [R12]
						next_s.receive_error_counter     = '0; // [R12]
					end else begin
						next_s.bo_seqs = s.bo_seqs + 8'h01; // [R12]
					end
				end
			end else if (any_err) begin
				if (bit_info_in.transmitter)
					next_s.transmit_error_counter = s.transmit_error_counter + 9'(`CEF_TX_ERR_STEP); // [R24] [R06]
				else if (s.receive_error_counter != 8'hff)
					next_s.receive_error_counter = s.receive_error_counter + 8'h01; // [R24] [R06]
			end else if (frame_evt_in.tx_frame_ok) begin
				if (s.transmit_error_counter != 9'h000)
					next_s.transmit_error_counter = s.transmit_error_counter - 9'h001; // [R06]
			end else if (frame_evt_in.rx_frame_ok) begin
				if (s.receive_error_counter > 8'(`CEF_PASSIVE_LIMIT))
					next_s.receive_error_counter = 8'(`CEF_REC_RETURN); // [R24]
				else if (s.receive_error_counter != 8'h00)
					next_s.receive_error_counter = s.receive_error_counter - 8'h01; // [R06]
			end
		end

		// An error passive transmitter holds off its next frame.
		if (frame_evt_in.tx_frame_ok && passive)
			next_s.susp = 4'(SUSPEND_BITS); // [R08]
		else if (tick && s.susp != 4'h0)
			next_s.susp = s.susp - 4'h1;

		// Low-power sequencing.
		case (s.lp)
			CEF_LP_SYNC: begin
				if (run_done)
					next_s.lp = CEF_LP_AWAKE; // [R18]
			end
			CEF_LP_AWAKE: begin
				if (s.low_power_request)
					next_s.lp = CEF_LP_DRAIN;
			end
			CEF_LP_DRAIN: begin
				// Frames still arrive here; entry waits for an empty transmit queue and an idle bus.
				if (!s.low_power_request)
					next_s.lp = CEF_LP_AWAKE;
				else if (!frame_evt_in.tx_pending && bit_info_in.field == CEF_FLD_IDLE)
					next_s.lp = CEF_LP_SLEEP; // [R19] [R20]
			end
			CEF_LP_SLEEP: begin
				// The run restarts so recessive bits seen while asleep never shorten the resync.
				if (!s.low_power_request) begin
					next_s.lp   = CEF_LP_WAKE; // [R22]
					next_s.rrun = '0; // [R22]
				end
			end
			CEF_LP_WAKE: begin
				// A frame already on the bus is dropped; sync waits for its interframe gap.
				if (run_done)
					next_s.lp = CEF_LP_AWAKE; // [R22] [R23] [R20]
			end
			default: begin
				next_s.lp = CEF_LP_SYNC;
			end
		endcase
		if (sleeping)
			next_s.susp = '0;

		// Register port.
		if (reg_wr_in) begin
			case (reg_addr_in)
				`CEF_OFF_MODE: begin
					next_s.low_power_request    = reg_wdata_in[`CEF_MODE_LPM_BIT];
					next_s.ovl_en = reg_wdata_in[`CEF_MODE_OVL_BIT];
				end
				`CEF_OFF_MASK: begin
					next_s.mask = reg_wdata_in[`CEF_SR_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				`CEF_OFF_MODE: begin
					next_s.rdata[`CEF_MODE_LPM_BIT] = s.low_power_request;
					next_s.rdata[`CEF_MODE_OVL_BIT] = s.ovl_en;
				end
				`CEF_OFF_MASK: begin
					next_s.rdata[`CEF_SR_W-1:0] = s.mask;
				end
				`CEF_OFF_STATUS: begin
					next_s.rdata[`CEF_SR_W-1:0] = status;
				end
				`CEF_OFF_ERRCNT: begin
					next_s.rdata[`CEF_ECR_REC_LSB +: 8] = s.receive_error_counter; // [R06]
					next_s.rdata[`CEF_ECR_TEC_LSB +: 9] = s.transmit_error_counter; // [R06]
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			s         <= '0;
			s.lp      <= CEF_LP_SYNC;
			s.rx_sync <= 2'h3;
			s.low_power_request     <= 1'(`CEF_MODE_RESET >> `CEF_MODE_LPM_BIT);
			s.mask    <= `CEF_MASK_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata_out            = s.rdata;
	assign error_frame_start_out    = s.err_start;
	assign overload_frame_start_out = s.ovl_start; // [R16]
	assign error_flag_passive_out   = passive; // [R08]
	assign bus_drive_enable_out     = awake && !busoff; // [R08] [R17]
	assign tx_permit_out            = awake && !busoff && !s.low_power_request && s.susp == 4'h0; // [R23]
	assign rx_enable_out            = awake; // [R17]
	assign irq_pending_out          = |(status & s.mask); // [R13] [R09] [R19] [R22]

endmodule : cef_error_fault_sleep
`default_nettype wire

// File: verilog/cef_cfg.svh
// Register offsets, field positions, reset values and bit-time counts of the error and sleep block.
`ifndef CEF_CFG_SVH
`define CEF_CFG_SVH

`define CEF_ADDR_W          8
`define CEF_OFF_MODE        8'h00
`define CEF_OFF_MASK        8'h04
`define CEF_OFF_STATUS      8'h08
`define CEF_OFF_ERRCNT      8'h0c

`define CEF_MODE_LPM_BIT    0
`define CEF_MODE_OVL_BIT    1
`define CEF_MODE_RESET      2'h0
`define CEF_MASK_RESET      13'h0000

`define CEF_SR_ACTIVE       0
`define CEF_SR_PASSIVE      1
`define CEF_SR_BUSOFF       2
`define CEF_SR_WARN         3
`define CEF_SR_SLEEP        4
`define CEF_SR_AWAKE        5
`define CEF_SR_ERR_LSB      8
`define CEF_SR_W            13
`define CEF_ECR_REC_LSB     0
`define CEF_ECR_TEC_LSB     16

`define CEF_WARN_LIMIT      96
`define CEF_PASSIVE_LIMIT   127
`define CEF_BUSOFF_LIMIT    255
`define CEF_REC_RETURN      119
`define CEF_TX_ERR_STEP     8
`define CEF_RECESSIVE_RUN   11
`define CEF_BUSOFF_SEQS     128
`define CEF_SUSPEND_BITS    8
`define CEF_STUFF_RUN       6
`define CEF_CRC_POLY        15'h4599

`endif

// File: verilog/cef_pkg.sv
// Types shared by the error, fault confinement and sleep block.
package cef_pkg;

	// Position of the current bit within a frame, as reported by the protocol engine.
	typedef enum logic [3:0] {
		CEF_FLD_IDLE         = 4'h0,
		CEF_FLD_ARB          = 4'h1,
		CEF_FLD_DATA         = 4'h2,
		CEF_FLD_CRC          = 4'h3,
		CEF_FLD_CRC_DELIM    = 4'h4,
		CEF_FLD_ACK_SLOT     = 4'h5,
		CEF_FLD_ACK_DELIM    = 4'h6,
		CEF_FLD_EOF          = 4'h7,
		CEF_FLD_INTERMISSION = 4'h8,
		CEF_FLD_FLAG         = 4'h9,
		CEF_FLD_DELIM        = 4'ha
	} cef_field_t;

	typedef struct packed {
		logic       tick;
		cef_field_t field;
		logic [2:0] index;
		logic       last;
		logic       stuff;
		logic       transmitter;
		logic       tx_level;
	} cef_bit_info_t;

	typedef struct packed {
		logic tx_pending;
		logic tx_frame_ok;
		logic rx_frame_ok;
		logic rx_to_mailbox;
	} cef_frame_evt_t;

	typedef enum logic [4:0] {
		CEF_LP_SYNC  = 5'h01,
		CEF_LP_AWAKE = 5'h02,
		CEF_LP_DRAIN = 5'h04,
		CEF_LP_SLEEP = 5'h08,
		CEF_LP_WAKE  = 5'h10
	} cef_lp_t;

	typedef struct packed {
		cef_lp_t     lp;
		logic [8:0]  transmit_error_counter;
		logic [7:0]  receive_error_counter;
		logic [3:0]  rrun;
		logic [7:0]  bo_seqs;
		logic [2:0]  srun;
		logic        last_bit;
		logic [14:0] crc;
		logic        crc_bad;
		logic [4:0]  errs;
		logic        err_start;
		logic        ovl_start;
		logic [3:0]  susp;
		logic        low_power_request;
		logic        ovl_en;
		logic [12:0] mask;
		logic [31:0] rdata;
		logic [1:0]  rx_sync;
	} cef_state_t;

endpackage : cef_pkg

// File: verif/cef_error_fault_sleep_monitor.sv
// Checker bound to the ports of the error, fault and sleep block.
`timescale 1ns/1ps
`default_nettype none
module cef_error_fault_sleep_monitor #(
	parameter int RECESSIVE_RUN = 11,
	parameter int BUSOFF_SEQS   = 128,
	parameter int SUSPEND_BITS  = 8
) (
	// Clock, reset and register port.
	input wire logic                    sys_clk_in,
	input wire logic                    rst_n_in,
	input wire logic                    reg_rd_in,
	input wire logic [31:0]             reg_rdata_out,
	// Bus and engine side.
	input wire logic                    can_rx_in,
	input wire cef_pkg::cef_bit_info_t  bit_info_in,
	input wire cef_pkg::cef_frame_evt_t frame_evt_in,
	input wire logic                    error_frame_start_out,
	input wire logic                    overload_frame_start_out,
	input wire logic                    bus_drive_enable_out,
	input wire logic                    tx_permit_out
);
	import cef_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// The pin is sampled through two flops, so a tick judges the level of two edges ago.
	sequence s_live;
		bit_info_in.tick && bus_drive_enable_out;
	endsequence
	property p_err(c);
		s_live ##0 c |=> error_frame_start_out;
	endproperty
	a_ack_missing: assert property (p_err(bit_info_in.field == CEF_FLD_ACK_SLOT &&
		bit_info_in.transmitter && $past(can_rx_in, 2))) else $error("ack slot without error");
	a_bit_mismatch: assert property (p_err(bit_info_in.field == CEF_FLD_DATA &&
		bit_info_in.transmitter && bit_info_in.tx_level != $past(can_rx_in, 2)))
		else $error("bit mismatch without error");
	a_form_delim: assert property (p_err((bit_info_in.field == CEF_FLD_CRC_DELIM ||
		bit_info_in.field == CEF_FLD_ACK_DELIM) && !$past(can_rx_in, 2)))
		else $error("dominant delimiter without error");
	a_overload_early: assert property (s_live ##0 (bit_info_in.field == CEF_FLD_INTERMISSION
		&& bit_info_in.index < 3'h2 && !$past(can_rx_in, 2)) |=> overload_frame_start_out)
		else $error("early intermission dominant without overload");
	a_err_cause: assert property (error_frame_start_out |-> $past(bit_info_in.tick))
		else $error("error frame without a sampled bit");
	a_ovl_cause: assert property (overload_frame_start_out |->
		$past(bit_info_in.tick || frame_evt_in.rx_to_mailbox)) else $error("overload without cause");
	a_quiet_no_tx: assert property (!bus_drive_enable_out |-> !tx_permit_out)
		else $error("transmit permitted while not driving");
	a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data outside read answer");
endmodule : cef_error_fault_sleep_monitor
bind cef_error_fault_sleep cef_error_fault_sleep_monitor #(.RECESSIVE_RUN(RECESSIVE_RUN),
	.BUSOFF_SEQS(BUSOFF_SEQS), .SUSPEND_BITS(SUSPEND_BITS)) i_mon (.sys_clk_in, .rst_n_in,
	.reg_rd_in, .reg_rdata_out, .can_rx_in, .bit_info_in, .frame_evt_in, .error_frame_start_out,
	.overload_frame_start_out, .bus_drive_enable_out, .tx_permit_out);
`default_nettype wire

// File: verif/cef_can_node.sv
// Model of the bus and the protocol engine that presents one sampled bit per request.
`timescale 1ns/1ps
`default_nettype none
module cef_can_node (
	// Clock and bit request.
	input  wire logic                    sys_clk_in,
	input  wire logic                    req_in,
	input  wire cef_pkg::cef_bit_info_t  info_in,
	input  wire logic                    level_in,
	output logic                         ack_out,
	// Bus side.
	output logic                         can_rx_out,
	output cef_pkg::cef_bit_info_t       bit_info_out
);
	import cef_pkg::*;
	initial begin
		ack_out = 1'b0;
		can_rx_out = 1'b1;
		bit_info_out = '0;
		forever begin
			@(posedge sys_clk_in);
			if (req_in) begin
				can_rx_out <= level_in;
				// Three edges let the level pass the two input flops before the sample tick.
				repeat (3) @(posedge sys_clk_in);
				bit_info_out <= info_in;
				@(posedge sys_clk_in);
				bit_info_out.tick <= 1'b0;
				ack_out <= 1'b1;
				@(posedge sys_clk_in);
				ack_out <= 1'b0;
				can_rx_out <= 1'b1;
			end
		end
	end
endmodule : cef_can_node
`default_nettype wire

// File: verif/cef_error_fault_sleep_tb.sv
// Self-checking bench of the error, fault and sleep block.
`timescale 1ns/1ps
`default_nettype none
module cef_error_fault_sleep_tb;
	import cef_pkg::*;
	typedef struct {cef_field_t f; logic t; logic tl; logic r; int n; int b; int dt; int dr;} cef_row_t;
	logic            sys_clk_in = 1'b0;
	logic            rst_n_in = 1'b0;
	logic [7:0]      reg_addr_in = 8'h0;
	logic [31:0]     reg_wdata_in = 32'h0;
	logic            reg_wr_in = 1'b0;
	logic            reg_rd_in = 1'b0;
	logic [31:0]     reg_rdata_out;
	logic            can_rx_in;
	cef_bit_info_t   bit_info_in;
	cef_frame_evt_t  frame_evt_in = '0;
	logic            error_frame_start_out, error_flag_passive_out, overload_frame_start_out;
	logic            bus_drive_enable_out, tx_permit_out, rx_enable_out, irq_pending_out;
	logic            req = 1'b0;
	logic            ack;
	logic            lvl = 1'b1;
	cef_bit_info_t   info = '0;
	logic [31:0]     d;
	int              n_fail = 0, n_compared = 0, n_err = 0, n_ovl = 0, transmit_error_counter = 0, receive_error_counter = 0, e;
	cef_row_t rows[4] = '{'{CEF_FLD_DATA, 0, 0, 0, 6, 9, 0, 1}, '{CEF_FLD_DATA, 1, 0, 1, 1, 10, 8, 0},
		'{CEF_FLD_ACK_DELIM, 0, 1, 0, 1, 11, 0, 1}, '{CEF_FLD_ACK_SLOT, 1, 1, 1, 1, 12, 8, 0}};
	cef_error_fault_sleep #(.BUSOFF_SEQS(2)) i_dut (.sys_clk_in, .rst_n_in, .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .can_rx_in, .bit_info_in,
		.frame_evt_in, .error_frame_start_out, .error_flag_passive_out, .overload_frame_start_out,
		.bus_drive_enable_out, .tx_permit_out, .rx_enable_out, .irq_pending_out);
	cef_can_node i_node (.sys_clk_in, .req_in(req), .info_in(info), .level_in(lvl), .ack_out(ack),
		.can_rx_out(can_rx_in), .bit_info_out(bit_info_in));
	always #2.5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		n_err += (error_frame_start_out === 1'b1);
		n_ovl += (overload_frame_start_out === 1'b1);
	end
	task automatic finish_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test
	task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge sys_clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, v, 1'b1};
		@(posedge sys_clk_in) reg_wr_in <= 1'b0;
	endtask : wr
	task automatic sr(logic [31:0] m, logic [31:0] x, logic [7:0] a = 8'h08);
		@(posedge sys_clk_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
		@(posedge sys_clk_in) reg_rd_in <= 1'b0;
		@(posedge sys_clk_in) d = reg_rdata_out;
		chk("register", x, d & m);
	endtask : sr
	task automatic ec;
		sr(32'hffffffff, {7'h0, transmit_error_counter[8:0], 8'h0, receive_error_counter[7:0]}, 8'h0c);
	endtask : ec
	task automatic bit1(cef_field_t f, logic [2:0] ix, logic t, logic tl, logic r);
		@(posedge sys_clk_in) info <= '{1'b1, f, ix, 1'b0, 1'b0, t, tl};
		{lvl, req} <= {r, 1'b1};
		repeat (20) begin
			@(posedge sys_clk_in);
			if (ack) break;
		end
		req <= 1'b0;
	endtask : bit1
	task automatic rrun(int n);
		repeat (n) bit1(CEF_FLD_IDLE, 3'h0, 1'b0, 1'b1, 1'b1);
	endtask : rrun
	task automatic mbox;
		@(posedge sys_clk_in) frame_evt_in.rx_to_mailbox <= 1'b1;
		@(posedge sys_clk_in) frame_evt_in.rx_to_mailbox <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
	endtask : mbox
	function automatic logic [3:0] st(int t, int r);
		logic p = t > 127 || r > 127;
		return {!p && (t > 96 || r > 96), t > 255, p, !p};
	endfunction : st
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		sr(32'h30, 32'h0);
		ec();
		sr(32'hffffffff, 32'h0, 8'h10);
		rrun(10);
		sr(32'h30, 32'h0);
		rrun(1);
		sr(32'h30, 32'h20);
		wr(8'h04, 32'h20);
		@(posedge sys_clk_in) chk("irq", 1, irq_pending_out);
		wr(8'h04, 32'h0);
		@(posedge sys_clk_in) chk("irq", 0, irq_pending_out);
		foreach (rows[i]) begin
			e = n_err;
			repeat (rows[i].n) bit1(rows[i].f, 3'h0, rows[i].t, rows[i].tl, rows[i].r);
			@(posedge sys_clk_in) chk("error frames", 1, n_err - e);
			transmit_error_counter += rows[i].dt;
			receive_error_counter += rows[i].dr;
			sr(32'h1 << rows[i].b, 32'h1 << rows[i].b);
			ec();
		end
		e = n_ovl;
		bit1(CEF_FLD_INTERMISSION, 3'h1, 1'b0, 1'b1, 1'b0);
		@(posedge sys_clk_in) chk("overload", 1, n_ovl - e);
		ec();
		mbox();
		chk("overload", 1, n_ovl - e);
		wr(8'h00, 32'h2);
		mbox();
		chk("overload", 2, n_ovl - e);
		@(posedge sys_clk_in) frame_evt_in.tx_pending <= 1'b1;
		wr(8'h00, 32'h1);
		rrun(1);
		sr(32'h30, 32'h20);
		@(posedge sys_clk_in) frame_evt_in.tx_pending <= 1'b0;
		rrun(1);
		sr(32'h30, 32'h10);
		chk("rx enable", 0, rx_enable_out);
		e = n_err;
		bit1(CEF_FLD_ACK_SLOT, 3'h0, 1'b1, 1'b1, 1'b1);
		@(posedge sys_clk_in) chk("error frames", 0, n_err - e);
		ec();
		wr(8'h00, 32'h0);
		rrun(10);
		sr(32'h30, 32'h10);
		rrun(1);
		sr(32'h30, 32'h20);
		chk("tx permit", 1, tx_permit_out);
		while (transmit_error_counter < 256) begin
			bit1(CEF_FLD_ACK_SLOT, 3'h0, 1'b1, 1'b1, 1'b1);
			transmit_error_counter += 8;
			sr(32'hf, {28'h0, st(transmit_error_counter, receive_error_counter)});
			if (transmit_error_counter < 256) chk("passive flag", transmit_error_counter > 127, error_flag_passive_out);
		end
		chk("drive", 0, bus_drive_enable_out);
		// A dominant bit restarts the recessive run so recovery counts from bus-off entry.
		bit1(CEF_FLD_IDLE, 3'h0, 1'b0, 1'b1, 1'b0);
		rrun(21);
		sr(32'h4, 32'h4);
		rrun(1);
		sr(32'h7, 32'h1);
		{transmit_error_counter, receive_error_counter} = 64'h0;
		ec();
		finish_test();
	end
endmodule : cef_error_fault_sleep_tb
`default_nettype wire
